// ===== tb_top.sv
// tb_top: self-checking bench for vmc_top
// assumes: vmc_master_model issues writes, stop causes driven here
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
bind vmc_top vmc_checker u_chk (.i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce), .i_wr(i_wr),
  .i_stop(i_stop), .i_max_speed(i_max_speed), .i_ramp_step(i_ramp_step),
  .o_mode_select_byte(o_mode_select_byte), .o_drive_status_word(o_drive_status_word),
  .o_speed_reference_velocity(o_speed_reference_velocity),
  .o_profile_velocity_target(o_profile_velocity_target), .o_velocity(o_velocity),
  .o_moving(o_moving));
module tb_top;
  import vmc_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  vmc_stop_t stop = '0;
  vmc_wr_t wr;
  logic [7:0] mode_rb;
  logic [15:0] status;
  logic [15:0] speed_rb;
  logic [31:0] prof_rb;
  logic signed [31:0] vel;
  logic moving;
  logic ce = 1'b1;
  logic signed [31:0] vel_hold;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  always #5 i_clock = ~i_clock;
  vmc_master_model m (.i_clock(i_clock), .o_wr(wr));
  vmc_top DUT (.i_clock(i_clock), .i_rst(i_rst), .i_ce(ce), .i_wr(wr), .i_stop(stop),
    .i_max_speed(16'h4e20), .i_ramp_max_velocity(16'h1388), .i_ramp_step(16'h0064),
    .o_mode_select_byte(mode_rb), .o_drive_status_word(status),
    .o_speed_reference_velocity(speed_rb), .o_profile_velocity_target(prof_rb),
    .o_velocity(vel), .o_moving(moving));
  task automatic wait_n(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic finish_test;
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      finish_test();
    end
  end
  // --------------------------------------------------
  // test sequence
  // --------------------------------------------------
  initial begin
    wait_n(20);
    `CHK("status_rst", 16'h0000, status)
    i_rst = 1'b0;
    wait_n(2);
    `CHK("status_idle", 16'h4000, status)
    `CHK("speed_rst", 16'h0000, speed_rb)
    m.put(2'h0, 32'h01);
    m.put(2'h1, 32'h64);
    wait_n(3);
    `CHK("moving_bad", 1'b0, moving)
    `CHK("ref_refused", 16'h0000, speed_rb)
    m.put(2'h0, 32'h17);
    m.put(2'h1, 32'h61a8);
    wait_n(4);
    `CHK("mode_rb", 8'h17, mode_rb)
    `CHK("speed_rb", 16'h61a8, speed_rb)
    `CHK("vel_clamp", 32'sd20000, vel)
    `CHK("status_run", 16'h0000, status)
    m.put(2'h1, 32'hfe0c);
    wait_n(4);
    `CHK("vel_new", -32'sd500, vel)
    m.put(2'h2, 32'h7918);
    wait_n(2);
    `CHK("speed_sat", 16'h7530, speed_rb)
    stop.halt = 1'b1;
    wait_n(4);
    `CHK("end_wait", 1'b0, status[14])
    stop.standstill = 1'b1;
    wait_n(4);
    `CHK("end_set", 1'b1, status[14])
    `CHK("moving_end", 1'b0, moving)
    stop = '0;
    m.put(2'h0, 32'h04);
    m.put(2'h1, 32'h1770);
    wait_n(3);
    `CHK("prof_rb", 32'h0000_1770, prof_rb)
    `CHK("vel_ramp", 1'b1, vel <= 32'sd300)
    ce = 1'b0;
    vel_hold = vel;
    wait_n(5);
    `CHK("ce_freeze", vel_hold, vel)
    ce = 1'b1;
    wait_n(60);
    `CHK("vel_lim", 32'sd5000, vel)
    `CHK("status_at", 16'h2000, status)
    m.put(2'h3, 32'h0000_4e20);
    wait_n(2);
    `CHK("prof_sat", 32'h0000_3390, prof_rb)
    stop.error = 1'b1;
    wait_n(3);
    `CHK("err_set", 1'b1, status[15])
    stop.standstill = 1'b1;
    wait_n(4);
    `CHK("err_end", 16'hc000, status)
    stop = '0;
    m.put(2'h1, 32'h64);
    wait_n(4);
    `CHK("err_clr", 1'b0, status[15])
    `CHK("moving_re", 1'b1, moving)
    finish_test();
  end
endmodule
`default_nettype wire

// ===== vmc_checker.sv
// vmc_checker: assertions on the ports of vmc_top
// assumes: bound into vmc_top from the bench, one clock domain
`timescale 1ns/1ns
`default_nettype none
module vmc_checker
  import vmc_pkg::*;
(
  input wire logic i_clock, // clock
  input wire logic i_rst, // reset
  input wire logic i_ce, // clock enable
  input wire vmc_wr_t i_wr, // write strobes
  input wire vmc_stop_t i_stop, // stop causes
  input wire logic [15:0] i_max_speed, // max speed
  input wire logic [15:0] i_ramp_step, // ramp step
  input wire logic [7:0] o_mode_select_byte, // mode byte
  input wire logic [15:0] o_drive_status_word, // status word
  input wire logic [15:0] o_speed_reference_velocity, // speed reference
  input wire logic [31:0] o_profile_velocity_target, // profile target
  input wire logic signed [31:0] o_velocity, // velocity
  input wire logic o_moving // running
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic [6:0] mode_code;
  wire logic valid_mode;
  wire logic stop_any;
  assign mode_code = o_mode_select_byte[6:0];
  assign valid_mode = (mode_code == VMC_MODE_SPEED) || (mode_code == VMC_MODE_PROFILE);
  assign stop_any = i_stop.halt | i_stop.quick_stop | i_stop.error;
  // --------------------------------------------------
  // start and end sequences
  // --------------------------------------------------
  sequence s_start;
    i_ce && i_wr.ref16_we && !i_wr.mode_we && valid_mode && !stop_any;
  endsequence
  sequence s_refused;
    i_ce && i_wr.ref16_we && !i_wr.mode_we && !valid_mode && !o_moving;
  endsequence
  sequence s_ended;
    $rose(o_drive_status_word[VMC_ST_END]) && $past(o_moving, 2);
  endsequence
  a_start_moves: assert property (s_start |-> ##2 o_moving)
    else $error("start did not run");
  a_bad_mode_idle: assert property (s_refused |-> ##1 !o_moving [*2])
    else $error("start taken without mode");
  a_end_standstill: assert property (s_ended |-> $past(i_stop.standstill, 2) && $past(stop_any, 2))
    else $error("mode ended without stop at standstill");
  a_err_flag_set: assert property (i_ce && i_stop.error |-> ##[1:2] o_drive_status_word[VMC_ST_ERR])
    else $error("error flag not set");
  a_info_speed_zero: assert property (mode_code == VMC_MODE_SPEED && $past(mode_code, 2) == VMC_MODE_SPEED |-> !o_drive_status_word[VMC_ST_INFO])
    else $error("reached flag in speed mode");
  a_status_low_zero: assert property (o_drive_status_word[12:0] == 13'h0)
    else $error("reserved status bits set");
  a_speed_ref_range: assert property ($signed(o_speed_reference_velocity) <= 16'sd30000 && $signed(o_speed_reference_velocity) >= -16'sd30000)
    else $error("speed reference out of range");
  a_prof_range: assert property ($signed(o_profile_velocity_target) <= VMC_PROF_MAX && $signed(o_profile_velocity_target) >= VMC_PROF_MIN)
    else $error("profile target out of range");
  a_vel_clamp: assert property (o_velocity <= $signed({16'h0, $past(i_max_speed, 3)}) && o_velocity >= -$signed({16'h0, $past(i_max_speed, 3)}))
    else $error("velocity above maximum speed");
  a_vel_ramp_step: assert property (mode_code == VMC_MODE_PROFILE && $past(mode_code, 2) == VMC_MODE_PROFILE |-> (o_velocity - $past(o_velocity)) <= $signed({16'h0, $past(i_ramp_step)}) && ($past(o_velocity) - o_velocity) <= $signed({16'h0, $past(i_ramp_step)}))
    else $error("profile velocity jumped");
endmodule
`default_nettype wire

// ===== vmc_master_model.sv
// vmc_master_model: fieldbus master issuing one-cycle write strobes
// assumes: the bench calls put() by hierarchical reference
`timescale 1ns/1ns
`default_nettype none
module vmc_master_model
  import vmc_pkg::*;
(
  input wire logic i_clock, // bus clock
  output var vmc_wr_t o_wr // write strobes and data
);
  initial o_wr = '0;
  // --------------------------------------------------
  // write task: 0 mode, 1 reference, 2 speed, 3 profile
  // --------------------------------------------------
  // mode codes then reference word
  task automatic put(input logic [1:0] kind, input logic [31:0] data);
    @(negedge i_clock);
    o_wr.mode_we = (kind == 2'h0);
    o_wr.mode_data = data[7:0];
    o_wr.ref16_we = (kind == 2'h1);
    o_wr.ref16_data = data[15:0];
    o_wr.speed_we = (kind == 2'h2);
    o_wr.speed_data = data[15:0];
    o_wr.prof_we = (kind == 2'h3);
    o_wr.prof_data = data;
    @(negedge i_clock);
    o_wr = '0;
  endtask
endmodule
`default_nettype wire

// ===== vmc_pkg.sv
// vmc_pkg: constants, types and register layout for the velocity mode control block
// assumes: single 100 MHz clock domain, fieldbus writes arrive as one-cycle strobes
`default_nettype none
package vmc_pkg;

  // --------------------------------------------------
  // register map
  // --------------------------------------------------
  localparam logic [15:0] VMC_ADDR_SPEED_REF = 16'h2108;
  localparam logic [15:0] VMC_SPEED_REF_RESET = 16'h0000;
  localparam logic [31:0] VMC_PROF_TGT_RESET = 32'h0000_0000;
  localparam logic [7:0] VMC_MODE_RESET = 8'h00;

  // --------------------------------------------------
  // mode byte codes (bits 0..6 of the mode byte)
  // --------------------------------------------------
  localparam logic [6:0] VMC_MODE_SPEED = 7'h17;
  localparam logic [6:0] VMC_MODE_PROFILE = 7'h04;
  localparam int VMC_MODE_MSB = 6;

  // --------------------------------------------------
  // status word bit positions
  // --------------------------------------------------
  localparam int VMC_ST_ERR = 15;
  localparam int VMC_ST_END = 14;
  localparam int VMC_ST_INFO = 13;

  // --------------------------------------------------
  // setpoint limits in rpm
  // --------------------------------------------------
  localparam logic signed [31:0] VMC_SPEED_MAX = 32'sd30000;
  localparam logic signed [31:0] VMC_SPEED_MIN = -32'sd30000;
  localparam logic signed [31:0] VMC_PROF_MAX = 32'sd13200;
  localparam logic signed [31:0] VMC_PROF_MIN = -32'sd13200;

  // --------------------------------------------------
  // types
  // --------------------------------------------------
  typedef enum logic [1:0] {
    VMC_IDLE = 2'b00,
    VMC_RUN = 2'b01,
    VMC_STOP = 2'b10,
    VMC_END = 2'b11
  } vmc_state_t;

  typedef enum logic [1:0] {
    VMC_SEL_NONE = 2'b00,
    VMC_SEL_SPEED = 2'b01,
    VMC_SEL_PROFILE = 2'b10
  } vmc_sel_t;

  // fieldbus write strobes with their data
  typedef struct packed {
    logic mode_we;
    logic [7:0] mode_data;
    logic ref16_we;
    logic [15:0] ref16_data;
    logic speed_we;
    logic [15:0] speed_data;
    logic prof_we;
    logic [31:0] prof_data;
  } vmc_wr_t;

  // stop causes and motion feedback from the drive
  typedef struct packed {
    logic halt;
    logic quick_stop;
    logic error;
    logic standstill;
  } vmc_stop_t;

endpackage
`default_nettype wire

// ===== vmc_ramp.sv
// vmc_ramp: velocity profile generator, moves the output toward a target by a fixed step
// assumes: target is already clamped; step is a positive rpm per enabled cycle
`timescale 1ns/1ns
`default_nettype none
module vmc_ramp
  import vmc_pkg::*;
(
  input wire logic i_clock, // system clock
  input wire logic i_rst, // async reset, active high
  input wire logic i_ce, // clock enable
  input wire logic i_bypass, // follow target directly
  input wire logic i_zero, // ramp toward zero (stop)
  input wire logic signed [31:0] i_target, // requested velocity
  input wire logic [15:0] i_step, // ramp step per cycle
  output logic signed [31:0] o_vel, // current velocity
  output logic o_at_target // velocity equals target
);

  logic signed [31:0] vel_q;
  logic signed [31:0] vel_d;
  logic signed [31:0] goal;
  logic signed [31:0] diff;
  logic signed [31:0] step_s;
  logic at_q;

  assign goal = i_zero ? 32'sd0 : i_target;
  assign diff = goal - vel_q;
  assign step_s = signed'({16'h0000, i_step});
  assign vel_d = i_bypass ? goal :
                 (diff > step_s) ? vel_q + step_s :
                 (diff < -step_s) ? vel_q - step_s : goal;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      vel_q <= 32'sd0;
      at_q <= 1'b0;
    end else if (i_ce) begin
      vel_q <= vel_d;
      at_q <= (vel_d == goal);
    end
  end

  assign o_vel = vel_q;
  assign o_at_target = at_q;

endmodule
`default_nettype wire

// ===== vmc_top.sv
// vmc_top: velocity mode control, direct speed control and profile velocity
// assumes: master writes arrive as one-cycle strobes; stop causes come from the drive
// Behaviour
// - mode byte code 17 hex selects direct speed control at reference velocity.
// - mode byte code 04 hex selects profile velocity toward target velocity.
// - master writes mode byte first, then the reference word starts motion.
// - direct speed control bypasses the profile generator, no ramp shaping.
// - profile velocity passes the target through the profile generator.
// - status bit 15 is the error flag.
// - status bit 14 reads 1 once the mode has terminated, 0 while running.
// - bit 13 shows target reached in profile velocity; reserved zero otherwise.
// - mode ends at standstill after halt, quick stop or error; an invalid mode byte write returns to idle at once unless a stop, end or run transition wins.
// - speed reference is signed 16 bit rpm, -30000..30000, reset 0, read/write.
// - direct speed is clamped to the maximum-speed setting.
// - profile target is signed 32 bit rpm, -13200..13200, read/write.
// - profile target is limited by maximum speed and ramp maximum velocity.
// - setpoint writes take effect immediately during motion.
`timescale 1ns/1ns
`default_nettype none
module vmc_top
  import vmc_pkg::*;
(
  input wire logic i_clock, // 100 MHz clock
  input wire logic i_rst, // async reset, active high
  input wire logic i_ce, // clock enable, freezes state when low
  input wire vmc_wr_t i_wr, // register write strobes and data
  input wire vmc_stop_t i_stop, // stop causes and standstill
  input wire logic [15:0] i_max_speed, // configured maximum speed, rpm
  input wire logic [15:0] i_ramp_max_velocity, // ramp generator maximum velocity, rpm
  input wire logic [15:0] i_ramp_step, // profile ramp step per cycle
  output logic [7:0] o_mode_select_byte, // mode byte readback
  output logic [15:0] o_drive_status_word, // status word
  output logic [15:0] o_speed_reference_velocity, // speed reference readback
  output logic [31:0] o_profile_velocity_target, // profile target readback
  output logic signed [31:0] o_velocity, // velocity command to the drive
  output logic o_moving // a velocity mode is running
);

  // --------------------------------------------------
  // registers
  // --------------------------------------------------
  logic [7:0] mode_q;
  logic [15:0] speed_q;
  logic [31:0] prof_q;
  logic err_q;
  vmc_state_t state_q;
  vmc_state_t state_d;
  vmc_sel_t sel_q;
  vmc_sel_t sel_d;
  logic [15:0] status_q;
  logic signed [31:0] vel_out_q;
  logic moving_q;

  // --------------------------------------------------
  // clamping of setpoints
  // --------------------------------------------------
  logic signed [31:0] speed_wr_s;
  logic signed [31:0] prof_wr_s;
  logic signed [31:0] speed_wr_lim;
  logic signed [31:0] prof_wr_lim;

  assign speed_wr_s = 32'(signed'(i_wr.speed_data));
  assign prof_wr_s = signed'(i_wr.prof_data);

  assign speed_wr_lim = (speed_wr_s > VMC_SPEED_MAX) ? VMC_SPEED_MAX :
                        (speed_wr_s < VMC_SPEED_MIN) ? VMC_SPEED_MIN : speed_wr_s;
  assign prof_wr_lim = (prof_wr_s > VMC_PROF_MAX) ? VMC_PROF_MAX :
                       (prof_wr_s < VMC_PROF_MIN) ? VMC_PROF_MIN : prof_wr_s;

  // reference word routes to the setpoint of the active mode
  logic ref_to_speed;
  logic ref_to_prof;
  logic signed [31:0] ref_s;
  logic signed [31:0] ref_speed_lim;
  logic signed [31:0] ref_prof_lim;

  assign ref_s = 32'(signed'(i_wr.ref16_data));
  assign ref_speed_lim = (ref_s > VMC_SPEED_MAX) ? VMC_SPEED_MAX :
                         (ref_s < VMC_SPEED_MIN) ? VMC_SPEED_MIN : ref_s;
  assign ref_prof_lim = (ref_s > VMC_PROF_MAX) ? VMC_PROF_MAX :
                        (ref_s < VMC_PROF_MIN) ? VMC_PROF_MIN : ref_s;
  assign ref_to_speed = i_wr.ref16_we && (sel_q == VMC_SEL_SPEED);
  assign ref_to_prof = i_wr.ref16_we && (sel_q == VMC_SEL_PROFILE);

  // --------------------------------------------------
  // mode decode
  // --------------------------------------------------
  logic [6:0] mode_code;
  logic code_speed;
  logic code_prof;

  assign mode_code = i_wr.mode_data[VMC_MODE_MSB:0];
  assign code_speed = (mode_code == VMC_MODE_SPEED);
  assign code_prof = (mode_code == VMC_MODE_PROFILE);

  // --------------------------------------------------
  // dynamic limits on the commanded velocity
  // --------------------------------------------------
  logic signed [31:0] max_s;
  logic signed [31:0] ramp_s;
  logic signed [31:0] prof_cap;
  logic signed [31:0] speed_cmd;
  logic signed [31:0] prof_cmd;
  logic signed [31:0] speed_in;

  assign max_s = signed'({16'h0000, i_max_speed});
  assign ramp_s = signed'({16'h0000, i_ramp_max_velocity});
  assign speed_in = 32'(signed'(speed_q));
  assign speed_cmd = (speed_in > max_s) ? max_s :
                     (speed_in < -max_s) ? -max_s : speed_in;
  assign prof_cap = (max_s < ramp_s) ? max_s : ramp_s;
  assign prof_cmd = (signed'(prof_q) > prof_cap) ? prof_cap :
                    (signed'(prof_q) < -prof_cap) ? -prof_cap : signed'(prof_q);

  // --------------------------------------------------
  // mode state machine
  // --------------------------------------------------
  logic stop_req;
  logic mode_ok;
  logic start;

  assign stop_req = i_stop.halt || i_stop.quick_stop || i_stop.error;
  assign mode_ok = code_speed || code_prof;
  // start only after a mode is chosen
  assign start = i_wr.ref16_we && (sel_q != VMC_SEL_NONE);

  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    if (i_wr.mode_we) begin
      sel_d = code_speed ? VMC_SEL_SPEED : code_prof ? VMC_SEL_PROFILE : VMC_SEL_NONE;
      if (!mode_ok) begin
        state_d = VMC_IDLE;
      end
    end
    unique case (state_q)
      VMC_IDLE: begin
        if (start && !stop_req) begin
          state_d = VMC_RUN;
        end
      end
      VMC_RUN: begin
        if (stop_req) begin
          state_d = VMC_STOP;
        end
      end
      VMC_STOP: begin
        if (i_stop.standstill) begin
          state_d = VMC_END;
        end
      end
      VMC_END: begin
        if (start && !stop_req) begin
          state_d = VMC_RUN;
        end
      end
    endcase
  end

  // --------------------------------------------------
  // profile generator
  // --------------------------------------------------
  logic signed [31:0] ramp_vel;
  logic ramp_at;
  logic signed [31:0] ramp_target;
  logic bypass;
  logic ramp_zero;

  assign bypass = (sel_q == VMC_SEL_SPEED);
  // setpoint registers feed the generator through the dynamic limits
  assign ramp_target = bypass ? speed_cmd : prof_cmd;
  assign ramp_zero = (state_q != VMC_RUN);

  vmc_ramp u_ramp (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_bypass(bypass),
    .i_zero(ramp_zero),
    .i_target(ramp_target),
    .i_step(i_ramp_step),
    .o_vel(ramp_vel),
    .o_at_target(ramp_at)
  );

  // --------------------------------------------------
  // status word
  // --------------------------------------------------
  logic [15:0] status_d;
  logic running;

  assign running = (state_q == VMC_RUN) || (state_q == VMC_STOP);

  always_comb begin
    status_d = 16'h0000;
    status_d[VMC_ST_ERR] = err_q;
    status_d[VMC_ST_END] = !running;
    // target reached in profile mode only
    status_d[VMC_ST_INFO] = (sel_q == VMC_SEL_PROFILE) && (state_q == VMC_RUN) && ramp_at;
  end

  // --------------------------------------------------
  // flip-flops
  // --------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mode_q <= VMC_MODE_RESET;
      sel_q <= VMC_SEL_NONE;
      state_q <= VMC_IDLE;
    end else if (i_ce) begin
      if (i_wr.mode_we) begin
        mode_q <= i_wr.mode_data;
      end
      sel_q <= sel_d;
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      speed_q <= VMC_SPEED_REF_RESET;
      prof_q <= VMC_PROF_TGT_RESET;
    end else if (i_ce) begin
      if (ref_to_speed) begin
        speed_q <= ref_speed_lim[15:0];
      end else if (i_wr.speed_we) begin
        speed_q <= speed_wr_lim[15:0];
      end
      if (ref_to_prof) begin
        prof_q <= ref_prof_lim;
      end else if (i_wr.prof_we) begin
        prof_q <= prof_wr_lim;
      end
    end
  end

  // error flag is sticky until a new start
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      err_q <= 1'b0;
    end else if (i_ce) begin
      if (i_stop.error) begin
        err_q <= 1'b1;
      end else if (start) begin
        err_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      status_q <= 16'h0000;
      vel_out_q <= 32'sd0;
      moving_q <= 1'b0;
    end else if (i_ce) begin
      status_q <= status_d;
      vel_out_q <= ramp_vel;
      moving_q <= running;
    end
  end

  // --------------------------------------------------
  // outputs
  // --------------------------------------------------
  assign o_mode_select_byte = mode_q;
  assign o_drive_status_word = status_q;
  assign o_speed_reference_velocity = speed_q;
  assign o_profile_velocity_target = prof_q;
  assign o_velocity = vel_out_q;
  assign o_moving = moving_q;

endmodule
`default_nettype wire
